// ### pkg/msrc_pkg.sv
// constants, state encoding and state record of the multi-source reset controller
package msrc_pkg;

    // ---------------------------------------------------------------
    // sizes
    // ---------------------------------------------------------------
    localparam int NUM_CORES = 4;
    localparam int CFG_BITS = 14;
    localparam int HCW_BITS = 32;
    localparam int CNT_BITS = 11;
    localparam int SRC_BITS = 6;
    localparam int SYNC_BITS = 7;

    // ---------------------------------------------------------------
    // timing, in clock cycles as printed
    // ---------------------------------------------------------------
    localparam int POR_RELEASE_CLKS = 1024;
    localparam int HARD_RELEASE_CLKS = 512;
    localparam int SOFT_RELEASE_CLKS = 515;
    localparam logic [CNT_BITS-1:0] POR_RELEASE_CNT = CNT_BITS'(POR_RELEASE_CLKS - 1);
    localparam logic [CNT_BITS-1:0] HARD_RELEASE_CNT = CNT_BITS'(HARD_RELEASE_CLKS - 1);
    localparam logic [CNT_BITS-1:0] SOFT_RELEASE_CNT = CNT_BITS'(SOFT_RELEASE_CLKS - 1);

    // ---------------------------------------------------------------
    // reset status bit positions
    // ---------------------------------------------------------------
    localparam int SRC_POR = 0;
    localparam int SRC_HARD_EXT = 1;
    localparam int SRC_SOFT_EXT = 2;
    localparam int SRC_WATCHDOG = 3;
    localparam int SRC_BUS_MON = 4;
    localparam int SRC_HOST = 5;
    localparam logic [SRC_BITS-1:0] STATUS_RESET = 6'h01;

    // ---------------------------------------------------------------
    // synchroniser lanes and their values under reset
    // ---------------------------------------------------------------
    localparam int SY_POR_N = 0;
    localparam int SY_HARD_LINE = 1;
    localparam int SY_SOFT_LINE = 2;
    localparam int SY_PLL_LOCK = 3;
    localparam int SY_WATCHDOG = 4;
    localparam int SY_BUS_MON = 5;
    localparam int SY_HOST = 6;
    localparam logic [SYNC_BITS-1:0] SYNC_RESET = 7'h06;

    localparam logic [CFG_BITS-1:0] CFG_RESET = 14'h0000;
    localparam logic [HCW_BITS-1:0] HCW_RESET = 32'h0000_0000;

    // ---------------------------------------------------------------
    // flow states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_POR_HOLD = 3'b000,
        ST_POR_DELAY = 3'b001,
        ST_PLL_WAIT = 3'b010,
        ST_HARD = 3'b011,
        ST_SOFT = 3'b100,
        ST_SETTLE = 3'b101,
        ST_IDLE = 3'b110
    } msrc_state_type;

    typedef struct packed {
        msrc_state_type state;
        logic [CNT_BITS-1:0] cnt;
        logic por_int;
        logic pll_reset;
        logic hard_oe;
        logic soft_oe;
        logic line_out;
        logic [NUM_CORES-1:0] core_reset;
        logic [CFG_BITS-1:0] por_cfg;
        logic [HCW_BITS-1:0] hard_cfg;
        logic hard_cfg_load;
        logic [SRC_BITS-1:0] status;
    } msrc_regs_type;

endpackage

// ### logic/msrc_sync.sv
// two-flop synchroniser bank for the asynchronous reset inputs
`timescale 1ns/1ns

module msrc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // async side
    input wire logic [WIDTH-1:0] async_in,
    // synchronous side
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // the first stage feeds only the second stage
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

// ### logic/msrc_reset_ctrl.sv
// multi-source reset controller: source gathering, flow sequencing and reset status
`timescale 1ns/1ns

module msrc_reset_ctrl (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // reset sources
    input wire logic power_on_reset_in_n,
    input wire logic watchdog_expired,
    input wire logic watchdog_enable,
    input wire logic bus_monitor_expired,
    input wire logic bus_monitor_enable,
    input wire logic host_reset_cmd,
    // system pll
    input wire logic system_pll_lock,
    output logic system_pll_reset,
    output logic internal_por,
    // open-drain hard reset line, active low
    input wire logic hard_reset_line_in_n,
    output logic hard_reset_line_out_n,
    output logic hard_reset_line_oe,
    // open-drain soft reset line, active low
    input wire logic soft_reset_line_in_n,
    output logic soft_reset_line_out_n,
    output logic soft_reset_line_oe,
    // configuration
    input wire logic [msrc_pkg::CFG_BITS-1:0] config_pins,
    input wire logic [msrc_pkg::HCW_BITS-1:0] hard_config_word_in,
    output logic [msrc_pkg::CFG_BITS-1:0] por_config,
    output logic [msrc_pkg::HCW_BITS-1:0] hard_config,
    output logic hard_config_load,
    // core resets and status
    output logic [msrc_pkg::NUM_CORES-1:0] core_reset,
    output logic [msrc_pkg::SRC_BITS-1:0] reset_status,
    output logic [2:0] flow_state
);

    // ---------------------------------------------------------------
    // input synchronisation
    // ---------------------------------------------------------------
    logic [msrc_pkg::SYNC_BITS-1:0] async_vec;
    logic [msrc_pkg::SYNC_BITS-1:0] sync_vec;

    always_comb begin
        async_vec = '0;
        async_vec[msrc_pkg::SY_POR_N] = power_on_reset_in_n;
        async_vec[msrc_pkg::SY_HARD_LINE] = hard_reset_line_in_n;
        async_vec[msrc_pkg::SY_SOFT_LINE] = soft_reset_line_in_n;
        async_vec[msrc_pkg::SY_PLL_LOCK] = system_pll_lock;
        async_vec[msrc_pkg::SY_WATCHDOG] = watchdog_expired;
        async_vec[msrc_pkg::SY_BUS_MON] = bus_monitor_expired;
        async_vec[msrc_pkg::SY_HOST] = host_reset_cmd;
    end

    msrc_sync #(
        .WIDTH(msrc_pkg::SYNC_BITS),
        .RST_VAL(msrc_pkg::SYNC_RESET)
    ) u_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in(async_vec),
        .sync_out(sync_vec)
    );

    // ---------------------------------------------------------------
    // source decode
    // ---------------------------------------------------------------
    logic por_active;
    logic pll_locked;
    logic wdg_event;
    logic bm_event;
    logic host_event;
    logic hard_ext_low;
    logic soft_ext_low;
    logic hard_any;
    logic [msrc_pkg::SRC_BITS-1:0] hard_src;

    msrc_pkg::msrc_regs_type r_q;
    msrc_pkg::msrc_regs_type r_d;

    assign por_active = !sync_vec[msrc_pkg::SY_POR_N];
    assign pll_locked = sync_vec[msrc_pkg::SY_PLL_LOCK];
    assign wdg_event = sync_vec[msrc_pkg::SY_WATCHDOG] && watchdog_enable;
    assign bm_event = sync_vec[msrc_pkg::SY_BUS_MON] && bus_monitor_enable;
    assign host_event = sync_vec[msrc_pkg::SY_HOST];
    // a low hard line only counts as external while we are not pulling it
    assign hard_ext_low = !sync_vec[msrc_pkg::SY_HARD_LINE] && !r_q.hard_oe;
    // external soft assertion counts only while no reset of ours is active
    assign soft_ext_low = !sync_vec[msrc_pkg::SY_SOFT_LINE] && (r_q.state == msrc_pkg::ST_IDLE);
    assign hard_any = hard_ext_low || wdg_event || bm_event;

    always_comb begin
        hard_src = '0;
        hard_src[msrc_pkg::SRC_HARD_EXT] = hard_ext_low;
        hard_src[msrc_pkg::SRC_WATCHDOG] = wdg_event;
        hard_src[msrc_pkg::SRC_BUS_MON] = bm_event;
    end

    // ---------------------------------------------------------------
    // flow sequencer
    // ---------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        r_d.hard_cfg_load = 1'b0;
        r_d.line_out = 1'b0;
        case (r_q.state)
            msrc_pkg::ST_POR_HOLD: begin
                r_d.cnt = '0;
                r_d.por_cfg = config_pins;
                if (!por_active) begin
                    r_d.state = msrc_pkg::ST_POR_DELAY;
                end
            end
            msrc_pkg::ST_POR_DELAY: begin
                r_d.cnt = r_q.cnt + 1'b1;
                if (r_q.cnt == msrc_pkg::POR_RELEASE_CNT) begin
                    r_d.cnt = '0;
                    r_d.por_int = 1'b0;
                    r_d.pll_reset = 1'b0;
                    r_d.state = msrc_pkg::ST_PLL_WAIT;
                end
            end
            msrc_pkg::ST_PLL_WAIT: begin
                if (pll_locked) begin
                    r_d.cnt = '0;
                    r_d.hard_cfg = hard_config_word_in;
                    r_d.hard_cfg_load = 1'b1;
                    r_d.state = msrc_pkg::ST_HARD;
                end
            end
            msrc_pkg::ST_HARD: begin
                // one release sequence serves power-on and every hard flow
                r_d.cnt = r_q.cnt + 1'b1;
                // our own released line reads low through the synchroniser for two more cycles,
                // so only internal sources are added here
                r_d.status = r_q.status | (hard_src & ~(6'h01 << msrc_pkg::SRC_HARD_EXT));
                if (r_q.cnt == msrc_pkg::HARD_RELEASE_CNT) begin
                    r_d.hard_oe = 1'b0;
                end
                if (r_q.cnt == msrc_pkg::SOFT_RELEASE_CNT) begin
                    r_d.soft_oe = 1'b0;
                    r_d.core_reset = '0;
                    r_d.state = msrc_pkg::ST_SETTLE;
                end
            end
            msrc_pkg::ST_SOFT: begin
                r_d.cnt = r_q.cnt + 1'b1;
                if (hard_any) begin
                    r_d = start_hard(r_q, hard_src);
                end else if (r_q.cnt == msrc_pkg::SOFT_RELEASE_CNT) begin
                    r_d.soft_oe = 1'b0;
                    r_d.core_reset = '0;
                    r_d.state = msrc_pkg::ST_SETTLE;
                end
            end
            msrc_pkg::ST_SETTLE: begin
                // let our own release ripple through the synchroniser first
                if (wdg_event || bm_event) begin
                    r_d = start_hard(r_q, hard_src & ~(6'h01 << msrc_pkg::SRC_HARD_EXT));
                end else if (host_event) begin
                    r_d = start_soft(r_q, msrc_pkg::SRC_HOST);
                end else if (sync_vec[msrc_pkg::SY_HARD_LINE] && sync_vec[msrc_pkg::SY_SOFT_LINE]) begin
                    r_d.state = msrc_pkg::ST_IDLE;
                end
            end
            msrc_pkg::ST_IDLE: begin
                if (hard_any) begin
                    r_d = start_hard(r_q, hard_src);
                end else if (host_event) begin
                    r_d = start_soft(r_q, msrc_pkg::SRC_HOST);
                end else if (soft_ext_low) begin
                    r_d = start_soft(r_q, msrc_pkg::SRC_SOFT_EXT);
                end
            end
            default: begin
                r_d.state = msrc_pkg::ST_POR_HOLD;
            end
        endcase
        // power-on overrides every other flow
        if (por_active) begin
            r_d.state = msrc_pkg::ST_POR_HOLD;
            r_d.cnt = '0;
            r_d.por_int = 1'b1;
            r_d.pll_reset = 1'b1;
            r_d.hard_oe = 1'b1;
            r_d.soft_oe = 1'b1;
            r_d.core_reset = '1;
            // straps are taken in the hold state only, once internal power-on is already up
            r_d.status = msrc_pkg::STATUS_RESET;
        end
        if (r_d.hard_oe) begin
            r_d.soft_oe = 1'b1;
        end
    end

    // hard flow entry: both lines, all cores, new hard configuration word
    function automatic msrc_pkg::msrc_regs_type start_hard(
        input msrc_pkg::msrc_regs_type cur,
        input logic [msrc_pkg::SRC_BITS-1:0] src
    );
        msrc_pkg::msrc_regs_type nxt;
        nxt = cur;
        nxt.state = msrc_pkg::ST_HARD;
        nxt.cnt = '0;
        nxt.hard_oe = 1'b1;
        nxt.soft_oe = 1'b1;
        nxt.core_reset = '1;
        nxt.hard_cfg = hard_config_word_in;
        nxt.hard_cfg_load = 1'b1;
        nxt.line_out = 1'b0;
        nxt.status = src;
        return nxt;
    endfunction

    // soft flow entry: soft line and cores only, configuration kept
    function automatic msrc_pkg::msrc_regs_type start_soft(
        input msrc_pkg::msrc_regs_type cur,
        input int src_bit
    );
        msrc_pkg::msrc_regs_type nxt;
        nxt = cur;
        nxt.state = msrc_pkg::ST_SOFT;
        nxt.cnt = '0;
        nxt.soft_oe = 1'b1;
        nxt.core_reset = '1;
        nxt.line_out = 1'b0;
        nxt.status = msrc_pkg::SRC_BITS'(6'h01 << src_bit);
        return nxt;
    endfunction

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            r_q.state <= msrc_pkg::ST_POR_HOLD;
            r_q.cnt <= '0;
            r_q.por_int <= 1'b1;
            r_q.pll_reset <= 1'b1;
            r_q.hard_oe <= 1'b1;
            r_q.soft_oe <= 1'b1;
            r_q.line_out <= 1'b0;
            r_q.core_reset <= '1;
            r_q.por_cfg <= msrc_pkg::CFG_RESET;
            r_q.hard_cfg <= msrc_pkg::HCW_RESET;
            r_q.hard_cfg_load <= 1'b0;
            r_q.status <= msrc_pkg::STATUS_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs, all straight from the state register
    // ---------------------------------------------------------------
    assign system_pll_reset = r_q.pll_reset;
    assign internal_por = r_q.por_int;
    assign hard_reset_line_out_n = r_q.line_out;
    assign hard_reset_line_oe = r_q.hard_oe;
    assign soft_reset_line_out_n = r_q.line_out;
    assign soft_reset_line_oe = r_q.soft_oe;
    assign por_config = r_q.por_cfg;
    assign hard_config = r_q.hard_cfg;
    assign hard_config_load = r_q.hard_cfg_load;
    assign core_reset = r_q.core_reset;
    assign reset_status = r_q.status;
    assign flow_state = r_q.state;

endmodule

// ### verification/msrc_board_model.sv
// board side model: pll lock behaviour and the two pulled-up open-drain reset wires
`timescale 1ns/1ns

module msrc_board_model #(
    parameter int LOCK_CLKS = 40
) (
    // clock
    input wire logic ref_clk,
    // pll
    input wire logic pll_reset,
    output logic pll_lock,
    // device side of the open-drain lines
    input wire logic hard_oe,
    input wire logic hard_out_n,
    input wire logic soft_oe,
    input wire logic soft_out_n,
    // external pulls commanded by the bench
    input wire logic ext_hard,
    input wire logic ext_soft,
    // resolved wire levels
    output logic hard_n,
    output logic soft_n
);
    int lock_cnt = 0;

    // lock state is lost whenever the pll is held in reset
    always @(posedge ref_clk) begin
        if (pll_reset) begin
            lock_cnt <= 0;
        end else if (lock_cnt < LOCK_CLKS) begin
            lock_cnt <= lock_cnt + 1;
        end
    end
    // the model assumes clock settings that keep the pll within its input and output range
    assign pll_lock = (lock_cnt == LOCK_CLKS);

    // pull-ups win unless some party pulls low; nobody drives high
    assign hard_n = !(hard_oe && !hard_out_n) && !ext_hard;
    assign soft_n = !(soft_oe && !soft_out_n) && !ext_soft;
endmodule

// ### verification/msrc_reset_ctrl_properties.sv
// port-level assertions for the multi-source reset controller
`timescale 1ns/1ns

module msrc_reset_ctrl_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // sources
    input wire logic watchdog_expired,
    input wire logic watchdog_enable,
    input wire logic bus_monitor_expired,
    input wire logic bus_monitor_enable,
    input wire logic host_reset_cmd,
    // outputs watched
    input wire logic system_pll_reset,
    input wire logic internal_por,
    input wire logic hard_reset_line_out_n,
    input wire logic hard_reset_line_oe,
    input wire logic soft_reset_line_out_n,
    input wire logic soft_reset_line_oe,
    input wire logic [msrc_pkg::CFG_BITS-1:0] por_config,
    input wire logic hard_config_load,
    input wire logic [msrc_pkg::NUM_CORES-1:0] core_reset,
    input wire logic [msrc_pkg::SRC_BITS-1:0] reset_status,
    input wire logic [2:0] flow_state
);
    logic [11:0] por_cnt_q;

    // counts sampled cycles spent in the power-on delay state
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            por_cnt_q <= 12'h000;
        end else if (flow_state == 3'b001) begin
            por_cnt_q <= por_cnt_q + 12'h001;
        end else begin
            por_cnt_q <= 12'h000;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    property p_soft_with_hard;
        hard_reset_line_oe |-> soft_reset_line_oe && core_reset == '1;
    endproperty
    a_soft_with_hard: assert property (p_soft_with_hard) else $error("soft line free while hard driven");
    property p_open_drain;
        (hard_reset_line_oe || soft_reset_line_oe) |-> !hard_reset_line_out_n && !soft_reset_line_out_n;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("reset line driven high");
    property p_cfg_keep;
        !$stable(por_config) |-> $past(internal_por);
    endproperty
    a_cfg_keep: assert property (p_cfg_keep) else $error("straps changed outside power-on");
    property p_por_delay;
        $fell(internal_por) |-> por_cnt_q == 12'd1024 && $fell(system_pll_reset);
    endproperty
    a_por_delay: assert property (p_por_delay) else $error("internal power-on release count wrong");
    property p_por_all;
        internal_por |-> system_pll_reset && hard_reset_line_oe && core_reset == '1;
    endproperty
    a_por_all: assert property (p_por_all) else $error("power-on not resetting everything");
    property p_hard_len;
        $fell(hard_reset_line_oe) |-> $past(hard_config_load, 512);
    endproperty
    a_hard_len: assert property (p_hard_len) else $error("hard line held wrong length");
    property p_soft_after;
        $fell(hard_reset_line_oe) |-> soft_reset_line_oe ##3 ($fell(soft_reset_line_oe) && core_reset == '0);
    endproperty
    a_soft_after: assert property (p_soft_after) else $error("soft line release not three after hard");
    property p_watchdog;
        watchdog_expired && watchdog_enable && flow_state == 3'b110
            |-> ##[1:4] (hard_reset_line_oe && reset_status[3]);
    endproperty
    a_watchdog: assert property (p_watchdog) else $error("watchdog expiry ignored");
    property p_bus_mon;
        bus_monitor_expired && bus_monitor_enable && flow_state == 3'b110
            |-> ##[1:4] (hard_reset_line_oe && reset_status[4]);
    endproperty
    a_bus_mon: assert property (p_bus_mon) else $error("bus monitor expiry ignored");
    property p_host;
        host_reset_cmd && flow_state == 3'b110 |-> ##[1:4] (soft_reset_line_oe && reset_status[5]);
    endproperty
    a_host: assert property (p_host) else $error("host command ignored");

    c_watchdog: cover property ($rose(reset_status[3]));
    c_host: cover property ($rose(reset_status[5]));
    c_soft_only: cover property ($rose(soft_reset_line_oe) && !hard_reset_line_oe);
endmodule

bind msrc_reset_ctrl msrc_reset_ctrl_checker u_chk (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .watchdog_expired(watchdog_expired),
    .watchdog_enable(watchdog_enable),
    .bus_monitor_expired(bus_monitor_expired),
    .bus_monitor_enable(bus_monitor_enable),
    .host_reset_cmd(host_reset_cmd),
    .system_pll_reset(system_pll_reset),
    .internal_por(internal_por),
    .hard_reset_line_out_n(hard_reset_line_out_n),
    .hard_reset_line_oe(hard_reset_line_oe),
    .soft_reset_line_out_n(soft_reset_line_out_n),
    .soft_reset_line_oe(soft_reset_line_oe),
    .por_config(por_config),
    .hard_config_load(hard_config_load),
    .core_reset(core_reset),
    .reset_status(reset_status),
    .flow_state(flow_state)
);

// ### verification/msrc_reset_ctrl_bench.sv
// self-checking bench for the multi-source reset controller
`timescale 1ns/1ns

module msrc_reset_ctrl_bench;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic por_n = 1'b0;
    logic [1:0] en = 2'b00;
    logic [4:0] src = 5'h00;
    logic [msrc_pkg::CFG_BITS-1:0] straps = 14'h2a5c;
    logic [msrc_pkg::HCW_BITS-1:0] hcw = 32'h1234_5678;
    logic lock, hard_n, soft_n, pll_rst, ipor, h_out_n, h_oe, s_out_n, s_oe, hc_load;
    logic [msrc_pkg::CFG_BITS-1:0] pcfg;
    logic [msrc_pkg::HCW_BITS-1:0] hcfg;
    logic [msrc_pkg::NUM_CORES-1:0] cores;
    logic [msrc_pkg::SRC_BITS-1:0] status;
    logic [2:0] fstate;
    int err_total = 0;
    int checks_done = 0;

    // host commands are driven at this 25 MHz rate, well below the host port limit
    initial forever #20 ref_clk = ~ref_clk;

    msrc_reset_ctrl dut (.ref_clk(ref_clk), .resetn(resetn), .power_on_reset_in_n(por_n),
        .watchdog_expired(src[0]), .watchdog_enable(en[0]), .bus_monitor_expired(src[1]),
        .bus_monitor_enable(en[1]), .host_reset_cmd(src[2]), .system_pll_lock(lock),
        .system_pll_reset(pll_rst), .internal_por(ipor), .hard_reset_line_in_n(hard_n),
        .hard_reset_line_out_n(h_out_n), .hard_reset_line_oe(h_oe), .soft_reset_line_in_n(soft_n),
        .soft_reset_line_out_n(s_out_n), .soft_reset_line_oe(s_oe), .config_pins(straps),
        .hard_config_word_in(hcw), .por_config(pcfg), .hard_config(hcfg), .hard_config_load(hc_load),
        .core_reset(cores), .reset_status(status), .flow_state(fstate));

    msrc_board_model #(.LOCK_CLKS(40)) board (.ref_clk(ref_clk), .pll_reset(pll_rst), .pll_lock(lock),
        .hard_oe(h_oe), .hard_out_n(h_out_n), .soft_oe(s_oe), .soft_out_n(s_out_n),
        .ext_hard(src[3]), .ext_soft(src[4]), .hard_n(hard_n), .soft_n(soft_n));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        repeat (4) @(posedge ref_clk);
        while (fstate !== 3'b110 && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        chk("idle_reached", 32'h1, 32'(fstate === 3'b110));
    endtask

    // raise the sources, drop them once the flow starts or after 20 cycles, then check the recorded sources
    task automatic trig(input logic [4:0] s, input logic fire, input logic [5:0] exp);
        int n;
        n = 0;
        src <= s;
        while (s_oe !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        src <= 5'h00;
        chk("flow_start", 32'(fire), 32'(s_oe));
        wait_idle();
        chk("reset_status", 32'(exp), 32'(status));
        $display("test done sources %b", s);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge ref_clk);
        err_total++;
        $display("Error run_length expected finish seen timeout");
        conclude();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (20) @(posedge ref_clk);
        por_n <= 1'b1;
        wait_idle();
        chk("reset_status", 32'h01, 32'(status));
        chk("por_config", 32'(14'h2a5c), 32'(pcfg));
        chk("hard_config", 32'h1234_5678, hcfg);
        chk("core_reset", 32'h0, 32'(cores));
        $display("test done power-on");
        straps <= 14'h1111;
        hcw <= 32'hcafe_0001;
        en <= 2'b11;
        trig(5'b00001, 1'b1, 6'h08);
        chk("hard_config", 32'hcafe_0001, hcfg);
        chk("por_config", 32'(14'h2a5c), 32'(pcfg));
        trig(5'b00010, 1'b1, 6'h10);
        hcw <= 32'h0bad_0002;
        trig(5'b00100, 1'b1, 6'h20);
        chk("hard_config", 32'hcafe_0001, hcfg);
        trig(5'b10000, 1'b1, 6'h04);
        trig(5'b01000, 1'b1, 6'h02);
        chk("hard_config", 32'h0bad_0002, hcfg);
        trig(5'b10001, 1'b1, 6'h08);
        en <= 2'b00;
        trig(5'b00001, 1'b0, 6'h08);
        trig(5'b00010, 1'b0, 6'h08);
        chk("por_config", 32'(14'h2a5c), 32'(pcfg));
        conclude();
    end
endmodule
